// >>> pattern_pkg.sv
// Package: register map, reset values and carrier types of the pattern unit
package pattern_pkg;
  localparam logic [19:0] ADDR_LOW_DIR      = 20'hEE009;
  localparam logic [19:0] ADDR_HIGH_DIR     = 20'hEE00A;
  localparam logic [19:0] ADDR_LOW_DATA     = 20'hFFFD9;
  localparam logic [19:0] ADDR_HIGH_DATA    = 20'hFFFDA;
  localparam logic [19:0] ADDR_OVERLAP_MODE = 20'hFFFA0;
  localparam logic [19:0] ADDR_TRIG_SEL     = 20'hFFFA1;
  localparam logic [19:0] ADDR_HIGH_ENABLE  = 20'hFFFA2;
  localparam logic [19:0] ADDR_LOW_ENABLE   = 20'hFFFA3;
  localparam logic [19:0] ADDR_HIGH_BUF     = 20'hFFFA4;
  localparam logic [19:0] ADDR_LOW_BUF      = 20'hFFFA5;
  localparam logic [19:0] ADDR_HIGH_BUF_ALT = 20'hFFFA6;
  localparam logic [19:0] ADDR_LOW_BUF_ALT  = 20'hFFFA7;

  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_TRIG_SEL     = 8'hFF;
  localparam logic [7:0] RST_OVERLAP_MODE = 8'hF0;
  localparam logic [7:0] OVERLAP_RSVD     = 8'hF0;
  localparam logic [7:0] ALL_ONES         = 8'hFF;
  localparam logic [7:0] UPPER_NIBBLE     = 8'hF0;
  localparam logic [7:0] LOWER_NIBBLE     = 8'h0F;

  // Register bus request
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // One 8-bit port: data and direction
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
  } port_state_t;
endpackage

// >>> group_trigger.sv
// Group trigger: picks one compare-match strobe per nibble group
`timescale 1ns/1ns
module group_trigger #(
  parameter int GROUPS = 4
) (
  input  wire logic [2*GROUPS-1:0] sel,
  input  wire logic [2:0]          match,
  output logic      [GROUPS-1:0]   fire
);
  // Channel decode: 00 ch0, 01 ch1, 1x ch2
  function automatic logic pick(input logic [1:0] s, input logic [2:0] m);
    if (s[1]) begin
      pick = m[2];
    end else if (s[0]) begin
      pick = m[1];
    end else begin
      pick = m[0];
    end
  endfunction

  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    assign fire[g] = pick(sel[2*g+1:2*g], match); // R16
  end
endmodule // group_trigger

// >>> pattern_port.sv
// Pattern port: one 8-bit data register with enable-gated transfer
`timescale 1ns/1ns
module pattern_port (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       wr_data,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] enable,
  input  wire logic [7:0] next_buf,
  input  wire logic [1:0] fire,
  output logic      [7:0] data
);
  logic [7:0] next_data;
  logic [7:0] bit_fire;

  // Lower nibble follows fire[0], upper nibble fire[1]
  assign bit_fire = {{4{fire[1]}}, {4{fire[0]}}};

  // Transfer wins over a software write on enabled bits
  always_comb begin
    next_data = data;
    if (wr_data) begin
      next_data = (data & enable) | (wdata & ~enable); // R3 R4
    end
    next_data = (next_data & ~(bit_fire & enable))
              | (next_buf & bit_fire & enable); // R5 R6 R13 R15
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      data <= pattern_pkg::RST_ZERO;
    end else begin
      data <= next_data;
    end
  end

  a_write_protect: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_data && fire == 2'b00) |=> ((data & $past(enable))
      == ($past(data) & $past(enable))))
    else $error("enabled bit changed by write"); // R3
  a_transfer_copy: assert property (@(posedge mclk) disable iff (!rst_b)
    (fire[0] && enable[0]) |=> data[0] == $past(next_buf[0]))
    else $error("transfer did not copy"); // R5
  a_blocked_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    (!wr_data && enable == 8'h00) |=> $stable(data))
    else $error("disabled bit changed"); // R13
  c_transfer: cover property (@(posedge mclk) disable iff (!rst_b)
    fire[1] && enable[7]);
endmodule // pattern_port

// >>> pattern_output_register_bank.sv
// Pattern output register bank: 16-bit timed pattern output registers
// Function
// [R1] Software sets low direction bits for pattern pins 7..0; write-only.
// [R2] Software sets high direction bits for pattern pins 15..8; write-only.
// [R3] Low data bits with transfer enable set ignore software writes.
// [R4] High data bits with transfer enable set ignore software writes.
// [R5] Group trigger copies low buffer nibble into low port data.
// [R6] Group trigger copies high buffer nibble into high port data.
// [R7] Low buffer clears on reset and hardware standby, not software standby.
// [R8] High buffer clears on reset and hardware standby only.
// [R9] Shared low trigger: buffer at A5, A7 reads ones.
// [R10] Split low trigger: group1 at A5 upper, group0 at A7 lower.
// [R11] Shared high trigger: buffer at A4, A6 reads ones.
// [R12] Split high trigger: group3 at A4 upper, group2 at A6 lower.
// [R13] Low enable 1 allows transfer; 0 blocks and holds output.
// [R14] Low enable register is read/write, clears on reset and hw standby.
// [R15] High enable gates high transfer; resets to zero.
// [R16] Two-bit trigger select per group: ch0, ch1, ch2; resets to FF.
// [R17] Select compare sets buffer addressing; direction enables pin drive.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
module pattern_output_register_bank (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        hw_standby,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic [2:0]  compare_match,
  output logic      [15:0] pattern_out,
  output logic      [15:0] pattern_oe
);
  pattern_pkg::bus_req_t    req;
  pattern_pkg::port_state_t low_port;
  pattern_pkg::port_state_t high_port;
  logic [7:0] low_dir;
  logic [7:0] high_dir;
  logic [7:0] low_enable;
  logic [7:0] high_enable;
  logic [7:0] trig_sel;
  logic [7:0] overlap_mode;
  logic [7:0] low_buf;
  logic [7:0] high_buf;
  logic [7:0] low_data;
  logic [7:0] high_data;
  logic [3:0] fire;
  logic       low_shared;
  logic       high_shared;
  logic [7:0] next_low_dir;
  logic [7:0] next_high_dir;
  logic [7:0] next_low_enable;
  logic [7:0] next_high_enable;
  logic [7:0] next_trig_sel;
  logic [7:0] next_overlap_mode;
  logic [7:0] next_low_buf;
  logic [7:0] next_high_buf;
  logic [7:0] next_rdata;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  // Shared addressing when both groups of a pair pick the same channel;
  // 10 and 11 both mean channel 2, so compare decoded channels
  function automatic logic same_trig(input logic [1:0] a,
                                     input logic [1:0] b);
    same_trig = (a[1] && b[1]) || (a == b);
  endfunction

  assign low_shared  = same_trig(trig_sel[3:2], trig_sel[1:0]);  // R17
  assign high_shared = same_trig(trig_sel[7:6], trig_sel[5:4]);  // R17

  group_trigger #(.GROUPS(4)) u_trig (
    .sel   (trig_sel),
    .match (compare_match),
    .fire  (fire)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Next values for all software-written registers except the port data registers
  always_comb begin
    next_low_dir      = low_dir;
    next_high_dir     = high_dir;
    next_low_enable   = low_enable;
    next_high_enable  = high_enable;
    next_trig_sel     = trig_sel;
    next_overlap_mode = overlap_mode;
    next_low_buf      = low_buf;
    next_high_buf     = high_buf;
    if (req.wr) begin
      if (req.addr == pattern_pkg::ADDR_LOW_DIR) begin
        next_low_dir = req.wdata; // R1
      end else if (req.addr == pattern_pkg::ADDR_HIGH_DIR) begin
        next_high_dir = req.wdata; // R2
      end else if (req.addr == pattern_pkg::ADDR_LOW_ENABLE) begin
        next_low_enable = req.wdata; // R14
      end else if (req.addr == pattern_pkg::ADDR_HIGH_ENABLE) begin
        next_high_enable = req.wdata; // R15
      end else if (req.addr == pattern_pkg::ADDR_TRIG_SEL) begin
        next_trig_sel = req.wdata; // R16
      end else if (req.addr == pattern_pkg::ADDR_OVERLAP_MODE) begin
        next_overlap_mode = req.wdata | pattern_pkg::OVERLAP_RSVD;
      end else if (req.addr == pattern_pkg::ADDR_LOW_BUF) begin
        // Split mode: only the upper nibble lives here
        if (low_shared) begin
          next_low_buf = req.wdata; // R9
        end else begin
          next_low_buf = (req.wdata & pattern_pkg::UPPER_NIBBLE)
                       | (low_buf & pattern_pkg::LOWER_NIBBLE); // R10
        end
      end else if (req.addr == pattern_pkg::ADDR_LOW_BUF_ALT) begin
        if (!low_shared) begin
          next_low_buf = (req.wdata & pattern_pkg::LOWER_NIBBLE)
                       | (low_buf & pattern_pkg::UPPER_NIBBLE); // R10
        end
      end else if (req.addr == pattern_pkg::ADDR_HIGH_BUF) begin
        if (high_shared) begin
          next_high_buf = req.wdata; // R11
        end else begin
          next_high_buf = (req.wdata & pattern_pkg::UPPER_NIBBLE)
                        | (high_buf & pattern_pkg::LOWER_NIBBLE); // R12
        end
      end else if (req.addr == pattern_pkg::ADDR_HIGH_BUF_ALT) begin
        if (!high_shared) begin
          next_high_buf = (req.wdata & pattern_pkg::LOWER_NIBBLE)
                        | (high_buf & pattern_pkg::UPPER_NIBBLE); // R12
        end
      end
    end
    // Hardware standby clears like reset; software standby keeps all
    if (hw_standby) begin
      next_low_dir      = pattern_pkg::RST_ZERO;
      next_high_dir     = pattern_pkg::RST_ZERO;
      next_low_enable   = pattern_pkg::RST_ZERO; // R14
      next_high_enable  = pattern_pkg::RST_ZERO;
      next_trig_sel     = pattern_pkg::RST_TRIG_SEL;
      next_overlap_mode = pattern_pkg::RST_OVERLAP_MODE;
      next_low_buf      = pattern_pkg::RST_ZERO; // R7
      next_high_buf     = pattern_pkg::RST_ZERO; // R8
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      low_dir      <= pattern_pkg::RST_ZERO;
      high_dir     <= pattern_pkg::RST_ZERO;
      low_enable   <= pattern_pkg::RST_ZERO; // R14
      high_enable  <= pattern_pkg::RST_ZERO; // R15
      trig_sel     <= pattern_pkg::RST_TRIG_SEL; // R16
      overlap_mode <= pattern_pkg::RST_OVERLAP_MODE;
      low_buf      <= pattern_pkg::RST_ZERO; // R7
      high_buf     <= pattern_pkg::RST_ZERO; // R8
    end else begin
      low_dir      <= next_low_dir;
      high_dir     <= next_high_dir;
      low_enable   <= next_low_enable;
      high_enable  <= next_high_enable;
      trig_sel     <= next_trig_sel;
      overlap_mode <= next_overlap_mode;
      low_buf      <= next_low_buf;
      high_buf     <= next_high_buf;
    end
  end

  // ----------------------------------------------------------------
  // Port data registers
  // ----------------------------------------------------------------
  // Data registers are not cleared by hw_standby (only by reset)
  pattern_port u_low (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .wr_data  (req.wr && req.addr == pattern_pkg::ADDR_LOW_DATA),
    .wdata    (req.wdata),
    .enable   (low_enable),
    .next_buf (low_buf),
    .fire     (fire[1:0]),
    .data     (low_data)
  );

  pattern_port u_high (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .wr_data  (req.wr && req.addr == pattern_pkg::ADDR_HIGH_DATA),
    .wdata    (req.wdata),
    .enable   (high_enable),
    .next_buf (high_buf),
    .fire     (fire[3:2]),
    .data     (high_data)
  );

  assign low_port  = '{data: low_data, dir: low_dir};
  assign high_port = '{data: high_data, dir: high_dir};

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Pins driven only where software has set the direction bit
  assign pattern_out = {high_port.data, low_port.data};
  assign pattern_oe  = {high_port.dir, low_port.dir}; // R17 R1 R2

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Direction registers are write-only and read as ones here
  always_comb begin
    next_rdata = pattern_pkg::RST_ZERO;
    if (req.rd) begin
      if (req.addr == pattern_pkg::ADDR_LOW_DATA) begin
        next_rdata = low_data;
      end else if (req.addr == pattern_pkg::ADDR_HIGH_DATA) begin
        next_rdata = high_data;
      end else if (req.addr == pattern_pkg::ADDR_LOW_DIR ||
                   req.addr == pattern_pkg::ADDR_HIGH_DIR) begin
        next_rdata = pattern_pkg::ALL_ONES;
      end else if (req.addr == pattern_pkg::ADDR_LOW_ENABLE) begin
        next_rdata = low_enable; // R14
      end else if (req.addr == pattern_pkg::ADDR_HIGH_ENABLE) begin
        next_rdata = high_enable;
      end else if (req.addr == pattern_pkg::ADDR_TRIG_SEL) begin
        next_rdata = trig_sel;
      end else if (req.addr == pattern_pkg::ADDR_OVERLAP_MODE) begin
        next_rdata = overlap_mode;
      end else if (req.addr == pattern_pkg::ADDR_LOW_BUF) begin
        next_rdata = low_shared ? low_buf
                   : (low_buf | pattern_pkg::LOWER_NIBBLE); // R9 R10
      end else if (req.addr == pattern_pkg::ADDR_LOW_BUF_ALT) begin
        next_rdata = low_shared ? pattern_pkg::ALL_ONES
                   : (low_buf | pattern_pkg::UPPER_NIBBLE); // R9 R10
      end else if (req.addr == pattern_pkg::ADDR_HIGH_BUF) begin
        next_rdata = high_shared ? high_buf
                   : (high_buf | pattern_pkg::LOWER_NIBBLE); // R11 R12
      end else if (req.addr == pattern_pkg::ADDR_HIGH_BUF_ALT) begin
        next_rdata = high_shared ? pattern_pkg::ALL_ONES
                   : (high_buf | pattern_pkg::UPPER_NIBBLE); // R11 R12
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= pattern_pkg::RST_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_alt_reads_ones: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd && addr == pattern_pkg::ADDR_LOW_BUF_ALT && low_shared)
      |=> rdata == 8'hFF)
    else $error("shared low alt address not all ones"); // R9
  a_split_low_keep: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && addr == pattern_pkg::ADDR_LOW_BUF && !low_shared && !hw_standby)
      |=> low_buf[3:0] == $past(low_buf[3:0]))
    else $error("split low write touched group 0"); // R10
  a_high_alt_ones: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd && addr == pattern_pkg::ADDR_HIGH_BUF_ALT && high_shared)
      |=> rdata == 8'hFF)
    else $error("shared high alt address not all ones"); // R11
  a_split_high_rd: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd && addr == pattern_pkg::ADDR_HIGH_BUF_ALT && !high_shared)
      |=> rdata[7:4] == 4'hF && rdata[3:0] == $past(high_buf[3:0]))
    else $error("split high alt read wrong"); // R12
  a_standby_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    hw_standby |=> low_buf == 8'h00 && high_buf == 8'h00
      && low_enable == 8'h00)
    else $error("standby did not clear"); // R7 R8 R14
  a_enable_write: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && addr == pattern_pkg::ADDR_HIGH_ENABLE && !hw_standby)
      |=> high_enable == $past(wdata))
    else $error("high enable not written"); // R15
  a_trigger_fire: assert property (@(posedge mclk) disable iff (!rst_b)
    (trig_sel[1:0] == 2'b01) |-> fire[0] == compare_match[1])
    else $error("group 0 trigger decode wrong"); // R16
  a_pin_enable: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && addr == pattern_pkg::ADDR_HIGH_DIR && !hw_standby)
      |=> pattern_oe[15:8] == $past(wdata))
    else $error("direction not driving pins"); // R17
  a_high_copy: assert property (@(posedge mclk) disable iff (!rst_b)
    (fire[3] && high_enable[7]) |=> high_data[7] == $past(high_buf[7]))
    else $error("high transfer missed"); // R6
  // Ignored writes, blocked transfers, the shared-select compare and the low direction write
  a_alt_write_ignore: assert property ( // R9
    @(posedge mclk) disable iff (!rst_b)
    (wr && addr == pattern_pkg::ADDR_LOW_BUF_ALT && low_shared && !hw_standby)
      |=> $stable(low_buf))
    else $error("shared low alt write changed buffer");
  a_high_blocked: assert property ( // R15
    @(posedge mclk) disable iff (!rst_b)
    (fire[3] && high_enable[7:4] == 4'h0
      && !(wr && addr == pattern_pkg::ADDR_HIGH_DATA))
      |=> high_data[7:4] == $past(high_data[7:4]))
    else $error("disabled high bits changed on transfer");
  a_codes_shared: assert property ( // R17
    @(posedge mclk) disable iff (!rst_b)
    (trig_sel[7] && trig_sel[5]) |-> high_shared)
    else $error("channel 2 codes not treated as shared");
  a_low_dir_write: assert property ( // R1
    @(posedge mclk) disable iff (!rst_b)
    (wr && addr == pattern_pkg::ADDR_LOW_DIR && !hw_standby)
      |=> pattern_oe[7:0] == $past(wdata))
    else $error("low direction not driving pins");
  c_split_low: cover property (@(posedge mclk) !low_shared && fire[0]);
  c_shared_high: cover property (@(posedge mclk) high_shared && fire[2]);
  c_standby: cover property (@(posedge mclk) hw_standby);
endmodule // pattern_output_register_bank

// >>> compare_match_source.sv
// Partner model: timer channels that raise compare-match pulses on request
`timescale 1ns/1ns
module compare_match_source (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       req,
  input  wire logic [1:0] req_ch,
  input  wire logic [3:0] req_delay,
  output logic      [2:0] compare_match
);
  logic       pend;
  logic [1:0] chan;
  logic [3:0] cnt;

  // ----------------------------------------------------------------
  // Match pulse timing
  // ----------------------------------------------------------------
  // A request arms one channel; its pulse comes req_delay+1 cycles after it is taken,
  // so the bench can ask for a prompt or a slow timer event
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend          <= 1'b0;
      chan          <= 2'h0;
      cnt           <= 4'h0;
      compare_match <= 3'h0;
    end else begin
      compare_match <= 3'h0; // Pulses last one cycle only
      if (req) begin
        pend <= 1'b1;
        chan <= req_ch;
        cnt  <= req_delay;
      end else if (pend) begin
        if (cnt == 4'h0) begin
          pend          <= 1'b0;
          compare_match <= 3'h1 << chan;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule // compare_match_source

// >>> pattern_output_register_bank_test.sv
// Testbench: register map, transfers and standby of the pattern bank
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module pattern_output_register_bank_test;
  logic        mclk;
  logic        rst_b;
  logic        hw_standby;
  logic        wr;
  logic        rd;
  logic        req;
  logic [19:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [2:0]  compare_match;
  logic [1:0]  req_ch;
  logic [3:0]  req_delay;
  logic [15:0] pattern_out;
  logic [15:0] pattern_oe;
  int          mismatches;
  int          n_checks;

  // ----------------------------------------------------------------
  // Clock, design and timer model
  // ----------------------------------------------------------------
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  pattern_output_register_bank i_dut (
    .mclk          (mclk),
    .rst_b         (rst_b),
    .hw_standby    (hw_standby),
    .addr          (addr),
    .wdata         (wdata),
    .wr            (wr),
    .rd            (rd),
    .rdata         (rdata),
    .compare_match (compare_match),
    .pattern_out   (pattern_out),
    .pattern_oe    (pattern_oe)
  );

  compare_match_source i_timer (
    .mclk          (mclk),
    .rst_b         (rst_b),
    .req           (req),
    .req_ch        (req_ch),
    .req_delay     (req_delay),
    .compare_match (compare_match)
  );

  // ----------------------------------------------------------------
  // Bus and timer tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic bus_write(input logic [19:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic read_check(input logic [19:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHECK(rdata, exp)
  endtask

  // Returns once the design has taken the match pulse
  task automatic fire(input logic [1:0] ch, input logic [3:0] dly);
    int i;
    @(posedge mclk);
    req       <= 1'b1;
    req_ch    <= ch;
    req_delay <= dly;
    @(posedge mclk);
    req <= 1'b0;
    #1;
    for (i = 0; i < 40 && compare_match === 3'h0; i++) begin
      @(posedge mclk);
      #1;
    end
    if (compare_match === 3'h0) begin
      mismatches++;
      report_and_stop();
    end
    @(posedge mclk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic check_reset_values();
    read_check(pattern_pkg::ADDR_LOW_ENABLE, 8'h00);
    read_check(pattern_pkg::ADDR_HIGH_ENABLE, 8'h00);
    read_check(pattern_pkg::ADDR_TRIG_SEL, 8'hFF);
    read_check(pattern_pkg::ADDR_LOW_BUF, 8'h00);
    read_check(pattern_pkg::ADDR_HIGH_BUF, 8'h00);
    `CHECK(pattern_out, 16'h0000)
    `CHECK(pattern_oe, 16'h0000)
  endtask

  task automatic check_direction();
    bus_write(pattern_pkg::ADDR_LOW_DIR, 8'hFF);
    bus_write(pattern_pkg::ADDR_HIGH_DIR, 8'h0F);
    `CHECK(pattern_oe, 16'h0FFF)
    read_check(pattern_pkg::ADDR_LOW_DIR, 8'hFF);
  endtask

  // Reset select puts every group on channel 2, so both pairs share
  task automatic check_shared();
    bus_write(pattern_pkg::ADDR_LOW_BUF, 8'hA5);
    read_check(pattern_pkg::ADDR_LOW_BUF, 8'hA5);
    bus_write(pattern_pkg::ADDR_LOW_BUF_ALT, 8'h12);
    read_check(pattern_pkg::ADDR_LOW_BUF_ALT, 8'hFF);
    read_check(pattern_pkg::ADDR_LOW_BUF, 8'hA5);
    bus_write(pattern_pkg::ADDR_HIGH_BUF, 8'h3C);
    read_check(pattern_pkg::ADDR_HIGH_BUF, 8'h3C);
    bus_write(pattern_pkg::ADDR_HIGH_BUF_ALT, 8'h55);
    read_check(pattern_pkg::ADDR_HIGH_BUF_ALT, 8'hFF);
    bus_write(pattern_pkg::ADDR_LOW_ENABLE, 8'hF0);
    read_check(pattern_pkg::ADDR_LOW_ENABLE, 8'hF0);
    bus_write(pattern_pkg::ADDR_LOW_DATA, 8'h3C);
    `CHECK(pattern_out[7:0], 8'h0C)
    bus_write(pattern_pkg::ADDR_LOW_DATA, 8'hFF);
    `CHECK(pattern_out[7:0], 8'h0F)
    fire(2'd2, 4'd0);
    `CHECK(pattern_out[7:0], 8'hAF)
    `CHECK(pattern_out[15:8], 8'h00)
  endtask

  // Groups 3 and 0 on channel 0, groups 2 and 1 on channel 1
  task automatic check_split();
    bus_write(pattern_pkg::ADDR_TRIG_SEL, 8'h14);
    read_check(pattern_pkg::ADDR_TRIG_SEL, 8'h14);
    bus_write(pattern_pkg::ADDR_LOW_BUF, 8'h5A);
    read_check(pattern_pkg::ADDR_LOW_BUF, 8'h5F);
    bus_write(pattern_pkg::ADDR_LOW_BUF_ALT, 8'hC3);
    read_check(pattern_pkg::ADDR_LOW_BUF_ALT, 8'hF3);
    bus_write(pattern_pkg::ADDR_HIGH_BUF, 8'h9E);
    read_check(pattern_pkg::ADDR_HIGH_BUF, 8'h9F);
    bus_write(pattern_pkg::ADDR_HIGH_BUF_ALT, 8'h71);
    read_check(pattern_pkg::ADDR_HIGH_BUF_ALT, 8'hF1);
    bus_write(pattern_pkg::ADDR_LOW_ENABLE, 8'hFF);
    bus_write(pattern_pkg::ADDR_HIGH_ENABLE, 8'hFF);
    read_check(pattern_pkg::ADDR_HIGH_ENABLE, 8'hFF);
    fire(2'd1, 4'd5);
    `CHECK(pattern_out, 16'h015F)
    bus_write(pattern_pkg::ADDR_HIGH_DATA, 8'h00);
    `CHECK(pattern_out[15:8], 8'h01)
    fire(2'd0, 4'd0);
    `CHECK(pattern_out, 16'h9153)
  endtask

  // Standby clears the bank but leaves the port data as they were
  task automatic check_standby();
    @(posedge mclk);
    hw_standby <= 1'b1;
    @(posedge mclk);
    hw_standby <= 1'b0;
    read_check(pattern_pkg::ADDR_LOW_BUF, 8'h00);
    read_check(pattern_pkg::ADDR_HIGH_BUF, 8'h00);
    read_check(pattern_pkg::ADDR_LOW_ENABLE, 8'h00);
    read_check(pattern_pkg::ADDR_HIGH_ENABLE, 8'h00);
    read_check(pattern_pkg::ADDR_TRIG_SEL, 8'hFF);
    `CHECK(pattern_out, 16'h9153)
    `CHECK(pattern_oe, 16'h0000)
  endtask

  // Codes 10 and 11 both mean channel 2, so the high pair still shares
  task automatic check_select_codes();
    bus_write(pattern_pkg::ADDR_TRIG_SEL, 8'hB5);
    read_check(pattern_pkg::ADDR_TRIG_SEL, 8'hB5);
    bus_write(pattern_pkg::ADDR_HIGH_BUF, 8'h6D);
    read_check(pattern_pkg::ADDR_HIGH_BUF, 8'h6D);
    read_check(pattern_pkg::ADDR_HIGH_BUF_ALT, 8'hFF);
    bus_write(pattern_pkg::ADDR_LOW_BUF, 8'hE7);
    bus_write(pattern_pkg::ADDR_LOW_ENABLE, 8'h3C);
    bus_write(pattern_pkg::ADDR_HIGH_ENABLE, 8'h0F);
    bus_write(pattern_pkg::ADDR_HIGH_DATA, 8'hA0);
    `CHECK(pattern_out[15:8], 8'hA1)
    fire(2'h1, 4'h2);
    `CHECK(pattern_out, 16'hA167)
    fire(2'h2, 4'h0);
    `CHECK(pattern_out, 16'hAD67)
  endtask

  // A reset in mid-run clears the pins and restores the register defaults
  task automatic check_mid_reset();
    @(posedge mclk);
    rst_b <= 1'b0;
    @(posedge mclk);
    #1;
    `CHECK(pattern_out, 16'h0000)
    `CHECK(pattern_oe, 16'h0000)
    @(posedge mclk);
    rst_b <= 1'b1;
    read_check(pattern_pkg::ADDR_TRIG_SEL, 8'hFF);
    read_check(pattern_pkg::ADDR_LOW_ENABLE, 8'h00);
    read_check(pattern_pkg::ADDR_HIGH_BUF, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b      = 1'b0;
    hw_standby = 1'b0;
    addr       = 20'h00000;
    wdata      = 8'h00;
    wr         = 1'b0;
    rd         = 1'b0;
    req        = 1'b0;
    req_ch     = 2'h0;
    req_delay  = 4'h0;
    mismatches = 0;
    n_checks   = 0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    check_reset_values();
    check_direction();
    check_shared();
    check_split();
    check_standby();
    check_select_codes();
    check_mid_reset();
    report_and_stop();
  end
endmodule // pattern_output_register_bank_test
